// >>> common/ccbx_consts.vh
// constants for the compare/clear/branch execution block
// assumes inclusion by bare name from core files
`ifndef CCBX_CONSTS_VH
`define CCBX_CONSTS_VH

// ********************************
// opcodes
// ********************************
`define CCBX_OP_CARRY_INV  8'hef
`define CCBX_OP_ZERO_R     8'hb0
`define CCBX_OP_ZERO_IND   8'hb1
`define CCBX_OP_INV_R      8'h60
`define CCBX_OP_INV_IND    8'h61
`define CCBX_OP_CMP        8'ha2
`define CCBX_OP_CIJ_EQ     8'hc2
`define CCBX_OP_CIJ_NE     8'hd2

// ********************************
// cycle counts and lengths
// ********************************
`define CCBX_CYC_SHORT     5'd4
`define CCBX_CYC_CMP       5'd6
`define CCBX_CYC_CIJ_TAKEN 5'd18
`define CCBX_CYC_CIJ_NOT   5'd16
`define CCBX_LEN_1         16'h0001
`define CCBX_LEN_2         16'h0002
`define CCBX_LEN_3         16'h0003

// ********************************
// flag bits and fields
// ********************************
`define CCBX_FLAG_C        7
`define CCBX_FLAG_Z        6
`define CCBX_FLAG_S        5
`define CCBX_FLAG_V        4
`define CCBX_SIGN_BIT      7
`define CCBX_BORROW_BIT    8
`define CCBX_INS_OPC       7:0
`define CCBX_INS_B1        15:8
`define CCBX_INS_B2        23:16
`define CCBX_NIB_HI        7:4
`define CCBX_NIB_LO        3:0
`define CCBX_WREG_BASE     4'hc
`define CCBX_STAT_BUSY     0
`define CCBX_STAT_TAKEN    1

// ********************************
// register word indices (byte address = index * 4)
// ********************************
`define CCBX_IDX_INSTR     10'h0d0
`define CCBX_IDX_PC        10'h0d1
`define CCBX_IDX_STATUS    10'h0d2
`define CCBX_IDX_REGADDR   10'h0d3
`define CCBX_IDX_REGDATA   10'h0d4
`define CCBX_IDX_FLAGS     10'h0d5
`define CCBX_IDX_MSB       11
`define CCBX_IDX_LSB       2

// ********************************
// reset values
// ********************************
`define CCBX_RST_FLAGS     8'h00
`define CCBX_RST_PC        16'h0000
`define CCBX_RST_BYTE      8'h00

`endif

// >>> core/ccbx_regfile.v
// register file memory with registered read data
// assumes one port, caller never reads and writes the same cycle
`timescale 1ns/10ps

module ccbx_regfile #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          clk,
    input  wire          resetn,
    input  wire          ce,
    input  wire [AW-1:0] addr,
    input  wire          we,
    input  wire [DW-1:0] wdata,
    output wire [DW-1:0] rdata
);

    reg [DW-1:0] mem [0:(1<<AW)-1];
    reg [DW-1:0] rdata_reg;

    // ********************************
    // storage
    // ********************************
    // array has no reset: contents are software's to load
    always @(posedge clk) begin
        if (ce && we) begin
            mem[addr] <= wdata;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            rdata_reg <= {DW{1'b0}};
        end else if (ce) begin
            rdata_reg <= mem[addr];
        end
    end

    assign rdata = rdata_reg;

endmodule // ccbx_regfile

// >>> core/ccbx_exec.v
// execution unit for carry invert, clear, invert, compare, compare-increment-jump
// assumes an AHB-Lite master on the same clock, single word transfers
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "ccbx_consts.vh"

module ccbx_exec #(
    parameter PCW = 16
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    output wire        busy
);

    // ********************************
    // states
    // ********************************
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_A    = 7'h02;
    localparam [6:0] ST_B    = 7'h04;
    localparam [6:0] ST_C    = 7'h08;
    localparam [6:0] ST_D    = 7'h10;
    localparam [6:0] ST_EXE  = 7'h20;
    localparam [6:0] ST_PAD  = 7'h40;

    reg  [6:0]     state_reg;
    reg  [4:0]     cnt_reg;
    reg  [4:0]     total_reg;
    reg  [7:0]     opCode_reg;
    reg  [7:0]     byte1_reg;
    reg  [7:0]     byte2_reg;
    reg  [7:0]     val1_reg;
    reg  [7:0]     val2_reg;
    reg  [7:0]     val3_reg;
    reg  [7:0]     flags_reg;
    reg  [PCW-1:0] pc_reg;
    reg  [7:0]     regAddr_reg;
    reg            taken_reg;
    reg            busy_reg;
    reg            wrPend_reg;
    reg  [9:0]     wrIdx_reg;
    reg            rdPend_reg;
    reg            rdStage_reg;
    reg  [9:0]     rdIdx_reg;
    reg  [31:0]    hrdata_reg;
    reg            hreadyout_reg;

    wire [7:0]     memRdata;
    wire           accept;
    wire           isIdle;
    wire           opValid;
    wire           busWr;

    reg  [1:0]     needReads;
    reg            isInd;
    reg            isCij;
    reg  [7:0]     rdAddr;
    reg            exeWe;
    reg  [7:0]     exeAddr;
    reg  [7:0]     exeWdata;
    reg  [7:0]     flags_next;
    reg  [PCW-1:0] pc_next;
    reg  [4:0]     total_next;
    reg            take;
    reg  [8:0]     diff;
    reg  [7:0]     invVal;
    reg            memWe;
    reg  [7:0]     memAddr;
    reg  [7:0]     memWdata;
    reg  [31:0]    rdValue;

    assign isIdle  = state_reg == ST_IDLE;
    assign accept  = hsel && hready && htrans[1];
    assign busWr   = wrPend_reg && isIdle;
    assign opValid = (hwdata[`CCBX_INS_OPC] == `CCBX_OP_CARRY_INV) ||
                     (hwdata[`CCBX_INS_OPC] == `CCBX_OP_ZERO_R)    ||
                     (hwdata[`CCBX_INS_OPC] == `CCBX_OP_ZERO_IND)  ||
                     (hwdata[`CCBX_INS_OPC] == `CCBX_OP_INV_R)     ||
                     (hwdata[`CCBX_INS_OPC] == `CCBX_OP_INV_IND)   ||
                     (hwdata[`CCBX_INS_OPC] == `CCBX_OP_CMP)       ||
                     (hwdata[`CCBX_INS_OPC] == `CCBX_OP_CIJ_EQ)    ||
                     (hwdata[`CCBX_INS_OPC] == `CCBX_OP_CIJ_NE);

    // ********************************
    // operand fetch and execute datapath
    // ********************************
    always @* begin
        isCij      = (opCode_reg == `CCBX_OP_CIJ_EQ) || (opCode_reg == `CCBX_OP_CIJ_NE);
        isInd      = (opCode_reg == `CCBX_OP_ZERO_IND) || (opCode_reg == `CCBX_OP_INV_IND);
        needReads  = 2'd0;
        exeWe      = 1'b0;
        exeAddr    = byte1_reg;
        exeWdata   = `CCBX_RST_BYTE;
        flags_next = flags_reg;
        pc_next    = pc_reg;
        total_next = `CCBX_CYC_SHORT;
        take       = 1'b0;
        diff       = {1'b0, val1_reg} - {1'b0, val2_reg};
        invVal     = isInd ? ~val2_reg : ~val1_reg;
        case (opCode_reg)
            `CCBX_OP_CARRY_INV: begin
                flags_next[`CCBX_FLAG_C] = ~flags_reg[`CCBX_FLAG_C];
                pc_next = pc_reg + `CCBX_LEN_1;
            end
            `CCBX_OP_ZERO_R, `CCBX_OP_ZERO_IND: begin
                needReads = isInd ? 2'd1 : 2'd0;
                exeWe     = 1'b1;
                exeAddr   = isInd ? val1_reg : byte1_reg;
                exeWdata  = `CCBX_RST_BYTE;
                pc_next   = pc_reg + `CCBX_LEN_2;
            end
            `CCBX_OP_INV_R, `CCBX_OP_INV_IND: begin
                needReads = isInd ? 2'd2 : 2'd1;
                exeWe     = 1'b1;
                exeAddr   = isInd ? val1_reg : byte1_reg;
                exeWdata  = invVal;
                flags_next[`CCBX_FLAG_Z] = (invVal == `CCBX_RST_BYTE);
                flags_next[`CCBX_FLAG_S] = invVal[`CCBX_SIGN_BIT];
                flags_next[`CCBX_FLAG_V] = 1'b0;
                pc_next   = pc_reg + `CCBX_LEN_2;
            end
            `CCBX_OP_CMP: begin
                // no write strobe at all: operands stay as they are
                needReads  = 2'd2;
                total_next = `CCBX_CYC_CMP;
                flags_next[`CCBX_FLAG_C] = diff[`CCBX_BORROW_BIT];
                flags_next[`CCBX_FLAG_Z] = (diff[7:0] == `CCBX_RST_BYTE);
                flags_next[`CCBX_FLAG_S] = diff[`CCBX_SIGN_BIT];
                flags_next[`CCBX_FLAG_V] = (val1_reg[`CCBX_SIGN_BIT] ^ val2_reg[`CCBX_SIGN_BIT]) &
                                           (val1_reg[`CCBX_SIGN_BIT] ^ diff[`CCBX_SIGN_BIT]);
                pc_next    = pc_reg + `CCBX_LEN_3;
            end
            `CCBX_OP_CIJ_EQ, `CCBX_OP_CIJ_NE: begin
                needReads = 2'd3;
                take      = (opCode_reg == `CCBX_OP_CIJ_EQ) ? (val3_reg == val2_reg)
                                                            : (val3_reg != val2_reg);
                exeWe     = 1'b1;
                exeAddr   = {`CCBX_WREG_BASE, byte1_reg[`CCBX_NIB_HI]};
                exeWdata  = val1_reg + 8'h01;
                total_next = take ? `CCBX_CYC_CIJ_TAKEN : `CCBX_CYC_CIJ_NOT;
                // range check is software's job; wrap is plain modulo
                pc_next   = pc_reg + `CCBX_LEN_3 +
                            (take ? {{(PCW-8){byte2_reg[7]}}, byte2_reg} : {PCW{1'b0}});
            end
            default: begin
                needReads = 2'd0;
            end
        endcase
    end

    // read address per fetch step; indirect pointer taken straight from memory output
    always @* begin
        case (state_reg)
            ST_A:    rdAddr = isCij ? {`CCBX_WREG_BASE, byte1_reg[`CCBX_NIB_HI]} : byte1_reg;
            ST_B:    rdAddr = (isCij || isInd) ? memRdata : byte2_reg;
            ST_C:    rdAddr = {`CCBX_WREG_BASE, byte1_reg[`CCBX_NIB_LO]};
            default: rdAddr = regAddr_reg;
        endcase
    end

    always @* begin
        memWe    = 1'b0;
        memAddr  = rdAddr;
        memWdata = exeWdata;
        if (state_reg == ST_EXE && exeWe) begin
            memWe   = 1'b1;
            memAddr = exeAddr;
        end else if (busWr && wrIdx_reg == `CCBX_IDX_REGDATA) begin
            memWe    = 1'b1;
            memAddr  = regAddr_reg;
            memWdata = hwdata[7:0];
        end
    end

    ccbx_regfile #(
        .AW (8),
        .DW (8)
    ) u_regfile (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .addr   (memAddr),
        .we     (memWe),
        .wdata  (memWdata),
        .rdata  (memRdata)
    );

    // ********************************
    // sequencer
    // ********************************
    always @(posedge clk) begin
        if (!resetn) begin
            state_reg  <= ST_IDLE;
            cnt_reg    <= 5'd0;
            total_reg  <= `CCBX_CYC_SHORT;
            opCode_reg <= `CCBX_RST_BYTE;
            byte1_reg  <= `CCBX_RST_BYTE;
            byte2_reg  <= `CCBX_RST_BYTE;
            val1_reg   <= `CCBX_RST_BYTE;
            val2_reg   <= `CCBX_RST_BYTE;
            val3_reg   <= `CCBX_RST_BYTE;
            flags_reg  <= `CCBX_RST_FLAGS;
            pc_reg     <= `CCBX_RST_PC;
            taken_reg  <= 1'b0;
            busy_reg   <= 1'b0;
            regAddr_reg <= `CCBX_RST_BYTE;
        end else if (ce) begin
            cnt_reg <= cnt_reg + 5'd1;
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 5'd0;
                    if (busWr) begin
                        case (wrIdx_reg)
                            `CCBX_IDX_PC:      pc_reg      <= hwdata[PCW-1:0];
                            `CCBX_IDX_FLAGS:   flags_reg   <= hwdata[7:0];
                            `CCBX_IDX_REGADDR: regAddr_reg <= hwdata[7:0];
                            `CCBX_IDX_INSTR: begin
                                if (opValid) begin
                                    opCode_reg <= hwdata[`CCBX_INS_OPC];
                                    byte1_reg  <= hwdata[`CCBX_INS_B1];
                                    byte2_reg  <= hwdata[`CCBX_INS_B2];
                                    busy_reg   <= 1'b1;
                                    // carry invert and direct clear need no operand
                                    if (hwdata[`CCBX_INS_OPC] == `CCBX_OP_CARRY_INV ||
                                        hwdata[`CCBX_INS_OPC] == `CCBX_OP_ZERO_R) begin
                                        state_reg <= ST_EXE;
                                    end else begin
                                        state_reg <= ST_A;
                                    end
                                end
                            end
                            default: begin
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_A: begin
                    state_reg <= ST_B;
                end
                ST_B: begin
                    val1_reg  <= memRdata;
                    state_reg <= (needReads == 2'd1) ? ST_EXE : ST_C;
                end
                ST_C: begin
                    val2_reg  <= memRdata;
                    state_reg <= (needReads == 2'd2) ? ST_EXE : ST_D;
                end
                ST_D: begin
                    val3_reg  <= memRdata;
                    state_reg <= ST_EXE;
                end
                ST_EXE: begin
                    flags_reg <= flags_next;
                    pc_reg    <= pc_next;
                    taken_reg <= take;
                    total_reg <= total_next;
                    if (cnt_reg == total_next - 5'd1) begin
                        state_reg <= ST_IDLE;
                        busy_reg  <= 1'b0;
                    end else begin
                        state_reg <= ST_PAD;
                    end
                end
                ST_PAD: begin
                    // padding to the documented cycle count
                    if (cnt_reg == total_reg - 5'd1) begin
                        state_reg <= ST_IDLE;
                        busy_reg  <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy_reg  <= 1'b0;
                end
            endcase
        end
    end

    // ********************************
    // AHB-Lite slave
    // ********************************
    always @* begin
        case (rdIdx_reg)
            `CCBX_IDX_PC:      rdValue = {{(32-PCW){1'b0}}, pc_reg};
            `CCBX_IDX_FLAGS:   rdValue = {24'h000000, flags_reg};
            `CCBX_IDX_REGADDR: rdValue = {24'h000000, regAddr_reg};
            `CCBX_IDX_REGDATA: rdValue = {24'h000000, memRdata};
            `CCBX_IDX_INSTR:   rdValue = {8'h00, byte2_reg, byte1_reg, opCode_reg};
            `CCBX_IDX_STATUS:  rdValue = {30'h00000000, taken_reg, busy_reg};
            default:           rdValue = 32'h00000000;
        endcase
    end

    // two wait states on reads so the memory output reflects a fresh address
    always @(posedge clk) begin
        if (!resetn) begin
            wrPend_reg    <= 1'b0;
            wrIdx_reg     <= 10'h000;
            rdPend_reg    <= 1'b0;
            rdStage_reg   <= 1'b0;
            rdIdx_reg     <= 10'h000;
            hrdata_reg    <= 32'h00000000;
            hreadyout_reg <= 1'b1;
        end else if (ce) begin
            wrPend_reg <= 1'b0;
            if (rdPend_reg) begin
                if (rdStage_reg) begin
                    hrdata_reg    <= rdValue;
                    hreadyout_reg <= 1'b1;
                    rdPend_reg    <= 1'b0;
                    rdStage_reg   <= 1'b0;
                end else begin
                    rdStage_reg <= 1'b1;
                end
            end else if (accept) begin
                if (hwrite) begin
                    wrPend_reg <= 1'b1;
                    wrIdx_reg  <= haddr[`CCBX_IDX_MSB:`CCBX_IDX_LSB];
                end else begin
                    rdPend_reg    <= 1'b1;
                    rdIdx_reg     <= haddr[`CCBX_IDX_MSB:`CCBX_IDX_LSB];
                    hreadyout_reg <= 1'b0;
                end
            end
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp     = 1'b0 & hsize[0];
    assign busy      = busy_reg;

endmodule // ccbx_exec

// >>> testbench/ccbx_exec_assertions.sv
// checker for bus timing and busy length of the execution block
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/10ps
module ccbx_exec_assertions (
    input wire        clk,
    input wire        resetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        busy
);
    reg        rdPh_reg;
    reg        wrPh_reg;
    reg  [9:0] idx_reg;
    reg  [1:0] kind_reg;
    reg  [4:0] len_reg;
    wire       take    = hsel && hready && htrans[1];
    wire       start   = wrPh_reg && hready && !busy && idx_reg == 10'h0d0;
    wire [7:0] op      = hwdata[7:0];
    wire       opShort = op == 8'hef || op == 8'hb0 || op == 8'hb1 || op == 8'h60 || op == 8'h61;
    wire       opCij   = op == 8'hc2 || op == 8'hd2;

    always @(posedge clk) begin
        if (!resetn) begin
            rdPh_reg <= 1'b0;
            wrPh_reg <= 1'b0;
            idx_reg  <= 10'h000;
            kind_reg <= 2'd0;
            len_reg  <= 5'd0;
        end else begin
            if (hready) begin
                rdPh_reg <= take && !hwrite;
                wrPh_reg <= take && hwrite;
                idx_reg  <= haddr[11:2];
            end
            if (start) begin
                kind_reg <= opShort ? 2'd1 : (opCij ? 2'd2 : 2'd0);
            end
            len_reg <= busy ? len_reg + 5'd1 : 5'd0;
        end
    end

    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    reset_idle_a: assert property (disable iff (1'b0) !resetn |=> hreadyout && !busy && hrdata == 32'h0)
        else $error("outputs not idle after reset");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
        else $error("read wait states wrong");
    rdata_hold_a: assert property ($changed(hrdata) |-> rdPh_reg)
        else $error("read data moved outside a read");
    busy_start_a: assert property (start && (opShort || opCij) |=> busy)
        else $error("instruction did not start");
    short_len_a: assert property ($fell(busy) && kind_reg == 2'd1 |-> len_reg == 5'd4)
        else $error("short instruction length wrong");
    cij_len_a: assert property ($fell(busy) && kind_reg == 2'd2 |-> len_reg == 5'd16 || len_reg == 5'd18)
        else $error("jump instruction length wrong");
endmodule // ccbx_exec_assertions

bind ccbx_exec ccbx_exec_assertions CHK (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .busy);

// >>> testbench/ccbx_ahb_master.sv
// bus master model issuing single word transfers
// assumes a lone slave whose hreadyout comes back as hready
`timescale 1ns/10ps
module ccbx_ahb_master (
    input  wire         clk,
    input  wire         hready,
    input  wire  [31:0] hrdata,
    output logic        hsel,
    output logic [31:0] haddr,
    output logic [1:0]  htrans,
    output logic        hwrite,
    output logic [2:0]  hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // ****************
    // call just after a rising edge; returns at the edge ending the data phase
    // ****************
    task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h0, idx, 2'b00};
        hwdata <= ~wd; // not yet valid, so an early sample shows
        do begin
            @(posedge clk);
            n++;
        end while (!hready && n < 64);
        htrans <= 2'b00;
        hwdata <= w ? wd : ~wd;
        do begin
            @(posedge clk);
            n++;
        end while (!hready && n < 64);
        rd = hrdata;
        ok = n < 64;
    endtask
endmodule // ccbx_ahb_master

// >>> testbench/tb_compare_clear_branch_exec.sv
// self-checking bench for the execution block
// assumes the bus master model and the bound checker
`timescale 1ns/10ps
module tb_compare_clear_branch_exec;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        ce = 1'b1;
    wire         hsel, hwrite, hreadyout, hresp, busy;
    wire  [31:0] haddr, hwdata, hrdata;
    wire  [1:0]  htrans;
    wire  [2:0]  hsize;
    int          fails = 0;
    int          num_checks = 0;
    localparam logic [9:0]  INS = 10'h0d0, PCX = 10'h0d1, STA = 10'h0d2;
    localparam logic [9:0]  RAD = 10'h0d3, RDT = 10'h0d4, FLG = 10'h0d5;
    localparam logic [31:0] CMP_D = 32'h02_05_80_7f, CMP_S = 32'h03_05_01_ff;
    localparam logic [39:0] CIJ_OP = 40'hc2_c2_d2_d2_c2, CIJ_D = 40'h02_02_02_07_09;
    localparam logic [39:0] CIJ_S = 40'h02_04_04_07_09;
    localparam logic [39:0] CIJ_O = 40'h10_80_80_7f_7f; // targets kept in -128..+127

    always #2.5 clk = ~clk;

    ccbx_ahb_master BFM (.clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
    ccbx_exec DUT (.clk, .resetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .busy);

    // ****************
    // shared tasks
    // ****************
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task xf(input logic w, input logic [9:0] i, input logic [31:0] d, output logic [31:0] r);
        logic ok;
        BFM.xfer(w, i, d, r, ok);
        if (!ok) begin
            fails++;
            $display("[FAIL] %0t bus transfer timed out", $time);
            end_of_test;
        end
    endtask
    task wr(input logic [9:0] i, input logic [31:0] d);
        logic [31:0] r;
        xf(1'b1, i, d, r);
    endtask
    task rdchk(input logic [9:0] i, input logic [31:0] e, input string what);
        logic [31:0] r;
        xf(1'b0, i, 32'h0, r);
        chk(r, e, what);
    endtask
    task setReg(input logic [7:0] a, input logic [7:0] v);
        wr(RAD, {24'h0, a});
        wr(RDT, {24'h0, v});
    endtask
    task regChk(input logic [7:0] a, input logic [7:0] e, input string what);
        wr(RAD, {24'h0, a});
        rdchk(RDT, {24'h0, e}, what);
    endtask
    // busy length is counted here, pc step checked afterwards
    task exec(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2, input int n,
              input logic [15:0] delta);
        logic [31:0] p;
        int c;
        xf(1'b0, PCX, 32'h0, p);
        wr(INS, {8'h00, b2, b1, op});
        c = 0;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            if (busy !== 1'b1) break;
            c++;
        end
        chk(c, n, "busy cycles");
        rdchk(PCX, {16'h0, p[15:0] + delta}, "pc");
    endtask

    // ****************
    // scenarios
    // ****************
    task t_regs;
        rdchk(FLG, 32'h0, "flags reset");
        rdchk(PCX, 32'h0, "pc reset");
        rdchk(STA, 32'h0, "status reset");
        wr(10'h000, 32'hffffffff);
        rdchk(10'h000, 32'h0, "unmapped");
        wr(FLG, 32'ha5);
        rdchk(FLG, 32'ha5, "flags rw");
        wr(INS, 32'h00000000);
        rdchk(STA, 32'h0, "bad opcode dropped");
        $display("test regs done");
    endtask
    task t_carry;
        wr(FLG, 32'h3f);
        exec(8'hef, 8'h00, 8'h00, 4, 16'h1);
        rdchk(FLG, 32'hbf, "carry set");
        exec(8'hef, 8'h00, 8'h00, 4, 16'h1);
        rdchk(FLG, 32'h3f, "carry clear");
        $display("test carry done");
    endtask
    task t_clear;
        setReg(8'h10, 8'h4f);
        setReg(8'h11, 8'h12);
        setReg(8'h12, 8'h5e);
        wr(FLG, 32'h0a);
        exec(8'hb0, 8'h10, 8'h00, 4, 16'h2);
        exec(8'hb1, 8'h11, 8'h00, 4, 16'h2);
        regChk(8'h10, 8'h00, "clear direct");
        regChk(8'h11, 8'h12, "pointer kept");
        regChk(8'h12, 8'h00, "clear indirect");
        rdchk(FLG, 32'h0a, "clear flags");
        $display("test clear done");
    endtask
    task t_invert;
        setReg(8'h20, 8'hff);
        wr(FLG, 32'h9f);
        exec(8'h60, 8'h20, 8'h00, 4, 16'h2);
        regChk(8'h20, 8'h00, "invert direct");
        rdchk(FLG, 32'hcf, "invert zero flags");
        setReg(8'h21, 8'h22);
        setReg(8'h22, 8'h0e);
        wr(FLG, 32'h1a);
        exec(8'h61, 8'h21, 8'h00, 4, 16'h2);
        regChk(8'h22, 8'hf1, "invert indirect");
        rdchk(FLG, 32'h2a, "invert sign flags");
        $display("test invert done");
    endtask
    task t_compare;
        logic [8:0] df;
        logic [7:0] d, s;
        for (int k = 0; k < 4; k++) begin
            d = CMP_D[8*k +: 8];
            s = CMP_S[8*k +: 8];
            df = {1'b0, d} - {1'b0, s};
            setReg(8'h30, d);
            setReg(8'h31, s);
            wr(FLG, 32'h05);
            exec(8'ha2, 8'h30, 8'h31, 6, 16'h3);
            rdchk(FLG, {24'h0, df[8], df[7:0] == 8'h0, df[7], (d[7] ^ s[7]) & (d[7] ^ df[7]), 4'h5},
                  "compare flags");
            regChk(8'h30, d, "compare dst");
            regChk(8'h31, s, "compare src");
        end
        $display("test compare done");
    endtask
    task t_cij;
        logic [7:0] op, d, s, o;
        logic tk;
        for (int k = 0; k < 5; k++) begin
            op = CIJ_OP[8*k +: 8];
            d = CIJ_D[8*k +: 8];
            s = CIJ_S[8*k +: 8];
            o = CIJ_O[8*k +: 8];
            tk = (op == 8'hc2) == (d == s);
            setReg(8'hc1, d);
            setReg(8'hc2, 8'h03);
            setReg(8'h03, s);
            wr(FLG, 32'hf5);
            wr(PCX, 32'h100);
            exec(op, 8'h21, o, tk ? 18 : 16, tk ? 16'h3 + {{8{o[7]}}, o} : 16'h3);
            regChk(8'hc2, 8'h04, "source pointer");
            rdchk(FLG, 32'hf5, "jump flags");
            rdchk(STA, {30'h0, tk, 1'b0}, "taken bit");
        end
        $display("test jump done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_regs;
        t_carry;
        t_clear;
        t_invert;
        t_compare;
        t_cij;
        end_of_test;
    end
endmodule // tb_compare_clear_branch_exec
